//--- core/adc_ctrl_params.svh
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH

`define ADR_CTRL 4'h0
`define ADR_CORNER 4'h1
`define ADR_POWER 4'h2
`define ADR_STATUS 4'h3
`define ADR_OFS_A 4'h4
`define ADR_OFS_B 4'h5

`define CTRL_SHAPE_BIT 0
`define CTRL_OFS_BIT 1
`define CTRL_GAIN_LSB 2
`define CTRL_GAIN_MSB 5
`define CORNER_LO_LSB 0
`define CORNER_LO_MSB 3
`define CORNER_HI_LSB 4
`define CORNER_HI_MSB 7
`define POWER_MODE_LSB 0
`define POWER_MODE_MSB 3
`define POWER_TAU_LSB 4
`define POWER_TAU_MSB 7

`define PINS_GLOBAL 3'h4
`define PINS_STBY_B 3'h5
`define PINS_STBY_A 3'h6
`define PINS_MUX 3'h7

`define LAT_BASE 22
`define LAT_SHAPED 26
`define SHAPE_ON_CYC 10
`define SHAPE_OFF_CYC 6

`define CLK_PERIOD_NS 8
`define WAKE_BUF_NS 100
`define WAKE_STBY_NS 1000
`define WAKE_GLOBAL_NS 20000

`define GAIN_MAX 4'hC
`define GAIN_FRAC 10
`define TAU_MAX 4'hB
`define TAU_BASE_SHIFT 18
`define OFS_LIMIT 10
`define SAMP_MAX 1023
`define SAMP_MIN -1024

`endif

//--- core/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  typedef logic signed [10:0] sample_type;

  typedef struct packed {
    sample_type a;
    sample_type b;
  } sample_pair_type;

  typedef enum logic [3:0] {
    PWR_NORMAL = 4'h0,
    PWR_BUF_B = 4'h9,
    PWR_BUF_A = 4'hA,
    PWR_BUF_AB = 4'hB,
    PWR_GLOBAL = 4'hC,
    PWR_STBY_B = 4'hD,
    PWR_STBY_A = 4'hE,
    PWR_MUX = 4'hF
  } pwr_mode_type;

  typedef enum logic [1:0] {
    SH_OFF = 2'h0,
    SH_ARMING = 2'h1,
    SH_ON = 2'h3,
    SH_DISARM = 2'h2
  } shape_state_type;

  typedef struct packed {
    logic [3:0] corner_hi;
    logic [3:0] corner_lo;
    logic [3:0] tau;
    logic [3:0] pwr;
    logic [3:0] gain;
    logic ofs_en;
    logic shape_en;
  } ctrl_type;

endpackage

//--- core/adc_digital_processing_control.sv
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_params.svh"
// Overview of operation
// - Shaping active lengthens output latency by four cycles, to 26 in total.
// - Shaping becomes fully active 10 cycles after the enabling register write.
// - After shaping is disabled, unshaped samples return after 6 cycles.
// - Shaping adds no group delay; only the fixed latency changes.
// - Gain is selectable from 0 dB to 6 dB in 0.5 dB steps.
// - Full scale shrinks with gain, 2 Vpp at 0 dB to 1 Vpp at 6 dB.
// - Gain comes out of reset at 0 dB.
// - Offset loop estimates and cancels dc offset within plus or minus 10 mV.
// - While enabled, the loop updates and subtracts its estimate every cycle.
// - Clearing the enable freezes the estimate, which is still subtracted.
// - Offset correction is disabled after reset.
// - Time-constant code 0 gives 256k cycles, doubling to 512M; 1100-1111 reserved.
// - Mode 0000 normal; 1001, 1010, 1011 float B, A or both outputs.
// - Mode 1100 global down, 1101 standby B, 1110 standby A.
// - Mode 1111 interleaves both channels on the channel A bus.
// - In pin configuration three pins select modes; no buffer disable there.
// - Valid data returns 100 ns, 1 us or 20 us after the respective mode.
// - Global down turns off converters, reference and drivers; outputs float.
// - Corner codes pick corners; shaping centre sits midway between them.
// - Shaping is disabled after reset.
module adc_digital_processing_control
  import adc_ctrl_pkg::*;
#(
  parameter int ACC_W = 41 // Offset accumulator width.
) (
  input wire logic sys_clk, // System clock, 125 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [3:0] reg_addr, // Register address.
  input wire logic [15:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [15:0] reg_rdata, // Read data, cycle after the strobe.
  input wire sample_pair_type samp_in, // Raw converter samples.
  input wire logic par_cfg, // High selects pin control of power modes.
  input wire logic mode_pin_one, // Mode control pin one.
  input wire logic mode_pin_two, // Mode control pin two.
  input wire logic mode_pin_three, // Mode control pin three.
  output sample_type chan_a_out, // Channel A output bus.
  output logic chan_a_oe, // Channel A drivers enabled.
  output sample_type chan_b_out, // Channel B output bus.
  output logic chan_b_oe, // Channel B drivers enabled.
  output logic chan_a_valid, // Channel A data valid.
  output logic chan_b_valid, // Channel B data valid.
  output logic conv_a_on, // Channel A converter powered.
  output logic conv_b_on, // Channel B converter powered.
  output logic ref_on, // Internal reference powered.
  output logic shaping_active // Shaped latency in force.
);

  localparam int PIPE_D = `LAT_SHAPED - 1;
  localparam int WAKE_BUF_CYC = (`WAKE_BUF_NS / `CLK_PERIOD_NS) < 1 ? 1 : `WAKE_BUF_NS / `CLK_PERIOD_NS;
  localparam int WAKE_STBY_CYC = (`WAKE_STBY_NS / `CLK_PERIOD_NS) < 1 ? 1 : `WAKE_STBY_NS / `CLK_PERIOD_NS;
  localparam int WAKE_GLB_CYC = (`WAKE_GLOBAL_NS / `CLK_PERIOD_NS) < 1 ? 1 : `WAKE_GLOBAL_NS / `CLK_PERIOD_NS;

  function automatic pwr_mode_type decode_mode(input logic [3:0] code);
    decode_mode = (code inside {PWR_BUF_B, PWR_BUF_A, PWR_BUF_AB, PWR_GLOBAL, PWR_STBY_B, PWR_STBY_A, PWR_MUX}) ?
      pwr_mode_type'(code) : PWR_NORMAL;
  endfunction

  function automatic pwr_mode_type pin_mode(input logic [2:0] pins);
    case (pins)
      `PINS_GLOBAL: pin_mode = PWR_GLOBAL;
      `PINS_STBY_B: pin_mode = PWR_STBY_B;
      `PINS_STBY_A: pin_mode = PWR_STBY_A;
      `PINS_MUX: pin_mode = PWR_MUX;
      default: pin_mode = PWR_NORMAL;
    endcase
  endfunction

  // Q2.10 linear factor for each half-decibel step, so 6 dB halves the full scale.
  function automatic logic [11:0] gain_factor(input logic [3:0] idx);
    case (idx)
      4'h0: gain_factor = 12'h400;
      4'h1: gain_factor = 12'h43D;
      4'h2: gain_factor = 12'h47D;
      4'h3: gain_factor = 12'h4C1;
      4'h4: gain_factor = 12'h509;
      4'h5: gain_factor = 12'h556;
      4'h6: gain_factor = 12'h5A7;
      4'h7: gain_factor = 12'h5FD;
      4'h8: gain_factor = 12'h658;
      4'h9: gain_factor = 12'h6B9;
      4'hA: gain_factor = 12'h71E;
      4'hB: gain_factor = 12'h78B;
      default: gain_factor = 12'h7FB;
    endcase
  endfunction

  // Corner frequency in thousandths of the sample rate.
  function automatic logic [9:0] corner_milli(input logic [3:0] code);
    case (code)
      4'h0: corner_milli = 10'h0FA;
      4'h1: corner_milli = 10'h10E;
      4'h2: corner_milli = 10'h122;
      4'h3: corner_milli = 10'h137;
      4'h4: corner_milli = 10'h14D;
      4'h5: corner_milli = 10'h165;
      4'h6: corner_milli = 10'h181;
      4'h7: corner_milli = 10'h1A4;
      4'h8: corner_milli = 10'h000;
      4'h9: corner_milli = 10'h050;
      4'hA: corner_milli = 10'h073;
      4'hB: corner_milli = 10'h08F;
      4'hC: corner_milli = 10'h0A7;
      4'hD: corner_milli = 10'h0BD;
      4'hE: corner_milli = 10'h0D2;
      default: corner_milli = 10'h0E6;
    endcase
  endfunction

  function automatic sample_type sat11(input logic signed [24:0] v);
    if (v > `SAMP_MAX) begin
      sat11 = sample_type'(`SAMP_MAX);
    end else if (v < `SAMP_MIN) begin
      sat11 = sample_type'(`SAMP_MIN);
    end else begin
      sat11 = v[10:0];
    end
  endfunction

  function automatic sample_type ofs_clamp(input logic signed [ACC_W-1:0] v);
    if (v > `OFS_LIMIT) begin
      ofs_clamp = sample_type'(`OFS_LIMIT);
    end else if (v < -`OFS_LIMIT) begin
      ofs_clamp = sample_type'(-`OFS_LIMIT);
    end else begin
      ofs_clamp = v[10:0];
    end
  endfunction

  ctrl_type ctrl_reg;
  shape_state_type shape_reg;
  logic [3:0] shape_cnt_reg;
  pwr_mode_type mode_reg;
  pwr_mode_type mode_next;
  logic [11:0] wake_cnt_reg;
  logic mux_phase_reg;
  logic signed [ACC_W-1:0] acc_reg [2];
  sample_type est_reg [2];
  sample_pair_type pipe_reg [PIPE_D];
  sample_type samp_ch [2];
  sample_type corr [2];
  sample_pair_type proc_pair;
  sample_pair_type tap_pair;
  logic [3:0] gain_eff;
  logic [3:0] tau_eff;
  logic [5:0] tau_shift;
  logic [9:0] center_milli;
  logic [10:0] corner_sum;
  logic shaped_lat;
  logic [4:0] tap_idx;
  logic signed [24:0] prod;

  assign gain_eff = (ctrl_reg.gain > `GAIN_MAX) ? `GAIN_MAX : ctrl_reg.gain;
  assign tau_eff = (ctrl_reg.tau > `TAU_MAX) ? `TAU_MAX : ctrl_reg.tau;
  assign tau_shift = 6'(`TAU_BASE_SHIFT) + 6'(tau_eff);
  assign corner_sum = 11'(corner_milli(ctrl_reg.corner_lo)) + 11'(corner_milli(ctrl_reg.corner_hi));
  assign center_milli = corner_sum[10:1];
  assign mode_next = par_cfg ? pin_mode({mode_pin_one, mode_pin_two, mode_pin_three})
    : decode_mode(ctrl_reg.pwr);
  assign shaped_lat = (shape_reg == SH_ON) || (shape_reg == SH_DISARM);
  // Tap moves by four stages only; the processing path itself is untouched by shaping.
  assign tap_idx = shaped_lat ? 5'(`LAT_SHAPED - 2) : 5'(`LAT_BASE - 2);
  assign tap_pair = pipe_reg[tap_idx];

  always_comb begin
    samp_ch[0] = samp_in.a;
    samp_ch[1] = samp_in.b;
    prod = '0;
    proc_pair = '0;
    for (int c = 0; c < 2; c++) begin
      corr[c] = sat11(25'(samp_ch[c]) - 25'(est_reg[c]));
      prod = 25'(corr[c]) * $signed({1'b0, gain_factor(gain_eff)});
      if (c == 0) begin
        proc_pair.a = sat11(prod >>> `GAIN_FRAC);
      end else begin
        proc_pair.b = sat11(prod >>> `GAIN_FRAC);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= '0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `ADR_CTRL: begin
          ctrl_reg.shape_en <= reg_wdata[`CTRL_SHAPE_BIT];
          ctrl_reg.ofs_en <= reg_wdata[`CTRL_OFS_BIT];
          ctrl_reg.gain <= reg_wdata[`CTRL_GAIN_MSB:`CTRL_GAIN_LSB];
        end
        `ADR_CORNER: begin
          ctrl_reg.corner_lo <= reg_wdata[`CORNER_LO_MSB:`CORNER_LO_LSB];
          ctrl_reg.corner_hi <= reg_wdata[`CORNER_HI_MSB:`CORNER_HI_LSB];
        end
        `ADR_POWER: begin
          ctrl_reg.pwr <= reg_wdata[`POWER_MODE_MSB:`POWER_MODE_LSB];
          ctrl_reg.tau <= reg_wdata[`POWER_TAU_MSB:`POWER_TAU_LSB];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `ADR_CTRL: reg_rdata <= 16'({gain_eff, ctrl_reg.ofs_en, ctrl_reg.shape_en});
        `ADR_CORNER: reg_rdata <= 16'({ctrl_reg.corner_hi, ctrl_reg.corner_lo});
        `ADR_POWER: reg_rdata <= 16'({ctrl_reg.tau, ctrl_reg.pwr});
        `ADR_STATUS: reg_rdata <= {wake_cnt_reg != 12'h000, shaped_lat, mode_reg, center_milli};
        `ADR_OFS_A: reg_rdata <= 16'(est_reg[0]);
        `ADR_OFS_B: reg_rdata <= 16'(est_reg[1]);
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // A request that flips back mid-count drops the count, so the old mode stays fully intact.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shape_reg <= SH_OFF;
      shape_cnt_reg <= '0;
    end else begin
      unique case (shape_reg)
        SH_OFF: begin
          if (ctrl_reg.shape_en) begin
            shape_reg <= SH_ARMING;
            shape_cnt_reg <= 4'h1;
          end
        end
        SH_ARMING: begin
          if (!ctrl_reg.shape_en) begin
            shape_reg <= SH_OFF;
          end else if (shape_cnt_reg == 4'(`SHAPE_ON_CYC - 1)) begin
            shape_reg <= SH_ON;
          end else begin
            shape_cnt_reg <= shape_cnt_reg + 4'h1;
          end
        end
        SH_ON: begin
          if (!ctrl_reg.shape_en) begin
            shape_reg <= SH_DISARM;
            shape_cnt_reg <= 4'h1;
          end
        end
        SH_DISARM: begin
          if (ctrl_reg.shape_en) begin
            shape_reg <= SH_ON;
          end else if (shape_cnt_reg == 4'(`SHAPE_OFF_CYC - 1)) begin
            shape_reg <= SH_OFF;
          end else begin
            shape_cnt_reg <= shape_cnt_reg + 4'h1;
          end
        end
      endcase
    end
  end

  // Freezing both accumulator and estimate keeps the held correction independent of tau writes.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < 2; c++) begin
        acc_reg[c] <= '0;
        est_reg[c] <= '0;
      end
    end else if (ctrl_reg.ofs_en) begin
      for (int c = 0; c < 2; c++) begin
        acc_reg[c] <= acc_reg[c] + ACC_W'(samp_ch[c]) - ACC_W'(est_reg[c]);
        est_reg[c] <= ofs_clamp(acc_reg[c] >>> tau_shift);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PIPE_D; i++) begin
        pipe_reg[i] <= '0;
      end
    end else begin
      pipe_reg[0] <= proc_pair;
      for (int i = 1; i < PIPE_D; i++) begin
        pipe_reg[i] <= pipe_reg[i-1];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= PWR_NORMAL;
      wake_cnt_reg <= '0;
    end else begin
      mode_reg <= mode_next;
      if (mode_next != mode_reg) begin
        unique case (mode_reg)
          PWR_BUF_A, PWR_BUF_B, PWR_BUF_AB: wake_cnt_reg <= 12'(WAKE_BUF_CYC);
          PWR_STBY_A, PWR_STBY_B: wake_cnt_reg <= 12'(WAKE_STBY_CYC);
          PWR_GLOBAL: wake_cnt_reg <= 12'(WAKE_GLB_CYC);
          default: wake_cnt_reg <= '0;
        endcase
      end else if (wake_cnt_reg != 12'h000) begin
        wake_cnt_reg <= wake_cnt_reg - 12'h001;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chan_a_out <= '0;
      chan_b_out <= '0;
      mux_phase_reg <= 1'b0;
      shaping_active <= 1'b0;
    end else begin
      mux_phase_reg <= !mux_phase_reg;
      shaping_active <= shaped_lat;
      chan_b_out <= tap_pair.b;
      if (mode_reg == PWR_MUX) begin
        chan_a_out <= mux_phase_reg ? tap_pair.b : tap_pair.a;
      end else begin
        chan_a_out <= tap_pair.a;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chan_a_oe <= 1'b0;
      chan_b_oe <= 1'b0;
      conv_a_on <= 1'b0;
      conv_b_on <= 1'b0;
      ref_on <= 1'b0;
      chan_a_valid <= 1'b0;
      chan_b_valid <= 1'b0;
    end else begin
      chan_a_oe <= !(mode_reg inside {PWR_GLOBAL, PWR_BUF_A, PWR_BUF_AB});
      chan_b_oe <= !(mode_reg inside {PWR_GLOBAL, PWR_BUF_B, PWR_BUF_AB, PWR_MUX});
      conv_a_on <= !(mode_reg inside {PWR_GLOBAL, PWR_STBY_A});
      conv_b_on <= !(mode_reg inside {PWR_GLOBAL, PWR_STBY_B});
      ref_on <= mode_reg != PWR_GLOBAL;
      chan_a_valid <= ~|wake_cnt_reg && !(mode_reg inside {PWR_GLOBAL, PWR_STBY_A, PWR_BUF_A, PWR_BUF_AB});
      chan_b_valid <= ~|wake_cnt_reg && !(mode_reg inside {PWR_GLOBAL, PWR_STBY_B, PWR_BUF_B, PWR_BUF_AB});
    end
  end

  logic [5:0] since_rst_reg; // Edges since reset; latency checks wait until the cleared pipeline has refilled.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      since_rst_reg <= '0;
    end else if (since_rst_reg != 6'h3F) begin
      since_rst_reg <= since_rst_reg + 6'h01;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_shape_on_delay: assert property ($rose(ctrl_reg.shape_en) && !shaped_lat |-> (!shaped_lat)[*5] ##1
    (!shaped_lat)[*5] ##1 (shaped_lat || !ctrl_reg.shape_en)) else $error("shaping not active after 10 cycles");
  a_shape_off_delay: assert property ($fell(ctrl_reg.shape_en) && shape_reg == SH_ON |->
    shaped_lat[*6] ##1 (!shaped_lat || ctrl_reg.shape_en)) else $error("shaping not off after 6 cycles");
  a_base_latency: assert property ($past(mode_reg) != PWR_MUX && shape_reg == SH_OFF
    && $past(shape_reg, 23) == SH_OFF && since_rst_reg > 6'(`LAT_SHAPED)
    |-> chan_a_out == $past(proc_pair.a, 22)) else $error("baseline latency is not 22");
  a_shaped_latency: assert property (mode_reg != PWR_MUX && shape_reg == SH_ON && $past(shape_reg, 27) == SH_ON
    && since_rst_reg > 6'(`LAT_SHAPED)
    |-> chan_b_out == $past(proc_pair.b, 26)) else $error("shaped latency is not 26");
  a_ofs_freeze: assert property (!ctrl_reg.ofs_en |=> $stable(est_reg[0]) && $stable(acc_reg[0]))
    else $error("offset estimate moved while frozen");
  a_ofs_limit: assert property (est_reg[1] <= `OFS_LIMIT && est_reg[1] >= -`OFS_LIMIT)
    else $error("offset estimate out of range");
  a_ofs_subtract: assert property (gain_eff == 4'h0 |-> proc_pair.a == sat11(25'(samp_in.a) - 25'(est_reg[0])))
    else $error("offset not subtracted");
  a_gain_range: assert property (ctrl_reg.gain > `GAIN_MAX |-> gain_eff == `GAIN_MAX)
    else $error("gain index beyond 6 dB");
  a_buf_disable: assert property (mode_reg == PWR_BUF_AB |=> !chan_a_oe && !chan_b_oe && conv_a_on)
    else $error("buffers not disabled");
  a_standby_split: assert property (mode_reg == PWR_STBY_B |=> !conv_b_on && conv_a_on && ref_on)
    else $error("channel B standby wrong");
  a_global_off: assert property (mode_reg == PWR_GLOBAL |=> !chan_a_oe && !chan_b_oe && !ref_on && !conv_a_on)
    else $error("global power down incomplete");
  a_pin_decode: assert property (par_cfg && {mode_pin_one, mode_pin_two, mode_pin_three} == `PINS_MUX
    |=> mode_reg == PWR_MUX) else $error("pin decode wrong");
  a_wake_hold: assert property ($fell(mode_reg == PWR_GLOBAL) |-> (!chan_a_valid)[*8])
    else $error("data valid too soon after wake");
  c_shape_on: cover property ($rose(shaping_active));
  c_mux_mode: cover property (mode_reg == PWR_MUX ##1 chan_a_oe && !chan_b_oe);
  c_ofs_freeze: cover property ($fell(ctrl_reg.ofs_en) && est_reg[0] != '0);

endmodule // adc_digital_processing_control
`default_nettype wire

//--- verification/output_receiver_model.sv
`timescale 1ns/1ps
`default_nettype none
module output_receiver_model
  import adc_ctrl_pkg::*;
(
  input wire logic sys_clk, // Sample clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire sample_type chan_a_out, // Channel A bus.
  input wire logic chan_a_oe, // Channel A drivers on.
  input wire sample_type chan_b_out, // Channel B bus.
  input wire logic chan_b_oe, // Channel B drivers on.
  output sample_type a_line, // Level on the channel A wires.
  output sample_type b_line // Level on the channel B wires.
);
  sample_type last_a_reg;
  sample_type last_b_reg;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      last_a_reg <= '0;
      last_b_reg <= '0;
    end else begin
      last_a_reg <= a_line;
      last_b_reg <= b_line;
    end
  end
  // A floating bus must not replay the last word, or dead drivers would go unseen.
  assign a_line = chan_a_oe ? chan_a_out : ~last_a_reg;
  assign b_line = chan_b_oe ? chan_b_out : ~last_b_reg;
endmodule // output_receiver_model
`default_nettype wire

//--- verification/adc_digital_processing_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_digital_processing_control_tb;
  import adc_ctrl_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  sample_pair_type samp_in = '0;
  logic par_cfg = 1'b0;
  logic mode_pin_one = 1'b0;
  logic mode_pin_two = 1'b0;
  logic mode_pin_three = 1'b0;
  sample_type chan_a_out, chan_b_out, a_line, b_line;
  logic chan_a_oe, chan_b_oe, chan_a_valid, chan_b_valid, conv_a_on, conv_b_on, ref_on, shaping_active;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  logic ramp = 1'b1;
  sample_pair_type hist [0:63];
  logic [15:0] d;
  logic [7:0] tbl [0:12];
  logic [9:0] pe;
  sample_type x1, x2;

  adc_digital_processing_control DUT (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .samp_in(samp_in), .par_cfg(par_cfg),
    .mode_pin_one(mode_pin_one), .mode_pin_two(mode_pin_two), .mode_pin_three(mode_pin_three),
    .chan_a_out(chan_a_out), .chan_a_oe(chan_a_oe), .chan_b_out(chan_b_out), .chan_b_oe(chan_b_oe),
    .chan_a_valid(chan_a_valid), .chan_b_valid(chan_b_valid), .conv_a_on(conv_a_on), .conv_b_on(conv_b_on),
    .ref_on(ref_on), .shaping_active(shaping_active));
  output_receiver_model RX (.sys_clk(sys_clk), .rst(rst), .chan_a_out(chan_a_out), .chan_a_oe(chan_a_oe),
    .chan_b_out(chan_b_out), .chan_b_oe(chan_b_oe), .a_line(a_line), .b_line(b_line));

  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    hist[cyc % 64] <= samp_in;
    cyc <= cyc + 1;
    if (ramp) begin
      samp_in <= '{a: sample_type'(cyc * 3), b: sample_type'(~cyc)};
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    cmp(v, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Between edges the bus shows what the coming edge samples: the input taken l edges before that edge.
  task automatic lat(input int l);
    @(negedge sys_clk);
    cmp({5'h00, a_line}, {5'h00, hist[(cyc - l) % 64].a});
  endtask
  task automatic wake(input int w);
    int n;
    n = 0;
    while (!(chan_a_valid === 1'b1 && chan_b_valid === 1'b1) && n < 3000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (w > 0) begin
      cmp({15'h0000, n >= w - 2 && n <= w + 4}, 16'h0001);
    end
  endtask
  function automatic logic [9:0] pexp(input logic [3:0] c);
    case (c)
      4'h9: return {5'h1F, 5'h17};
      4'hA: return {5'h1F, 5'h0F};
      4'hB: return {5'h1F, 5'h07};
      4'hC: return {5'h1F, 5'h00};
      4'hD: return {5'h07, 5'h05};
      4'hE: return {5'h07, 5'h03};
      4'hF: return {5'h1F, 5'h17};
      default: return {5'h1F, 5'h1F};
    endcase
  endfunction
  function automatic int wk(input logic [3:0] c);
    case (c)
      4'h9, 4'hA, 4'hB: return 12;
      4'hD, 4'hE: return 125;
      4'hC: return 2500;
      default: return 0;
    endcase
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // The whole sequence needs some 7000 cycles, the two global wake-ups being most of it.
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    stop_test;
  end

  initial begin
    tbl = '{8'h00, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'hCC, 8'hDD, 8'hEE, 8'hFF, 8'h90};
    idle(16);
    rst <= 1'b0;
    rdc(4'h0, 16'h0000);
    cmp({15'h0000, shaping_active}, 16'h0000);
    $display("test reset done");
    idle(30);
    lat(22);
    wr(4'h0, 16'h0001);
    idle(10);
    cmp({15'h0000, shaping_active}, 16'h0000);
    idle(1);
    cmp({15'h0000, shaping_active}, 16'h0001);
    idle(30);
    lat(26);
    rd(4'h3, d);
    cmp({15'h0000, d[14]}, 16'h0001);
    wr(4'h0, 16'h0000);
    idle(6);
    cmp({15'h0000, shaping_active}, 16'h0001);
    idle(1);
    cmp({15'h0000, shaping_active}, 16'h0000);
    idle(30);
    lat(22);
    $display("test shaping done");
    wr(4'h1, 16'h0079);
    rd(4'h3, d);
    cmp({6'h00, d[9:0]}, 16'h00FA);
    wr(4'h1, 16'h00BD);
    rd(4'h3, d);
    cmp({6'h00, d[9:0]}, 16'h00A6);
    $display("test corners done");
    for (int k = 0; k < 13; k++) begin
      wr(4'h0, 16'(k << 2));
      rdc(4'h0, 16'(k << 2));
    end
    ramp <= 1'b0;
    samp_in <= '{a: 11'sd600, b: -11'sd600};
    wr(4'h0, 16'h003C);
    rdc(4'h0, 16'h0030);
    idle(30);
    cmp({5'h00, a_line}, 16'h03FF);
    cmp({5'h00, b_line}, 16'h0400);
    $display("test gain done");
    samp_in <= '{a: 11'sd1000, b: 11'sd0};
    wr(4'h0, 16'h0002);
    idle(400);
    rdc(4'h4, 16'h0001);
    rdc(4'h5, 16'h0000);
    wr(4'h0, 16'h0000);
    idle(100);
    rdc(4'h4, 16'h0001);
    idle(30);
    cmp({5'h00, a_line}, 16'h03E7);
    wr(4'h2, 16'h00F0);
    rdc(4'h2, 16'h00F0);
    @(posedge sys_clk);
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    rdc(4'h4, 16'h0000);
    rdc(4'h2, 16'h0000);
    wr(4'h6, 16'hFFFF);
    rdc(4'h6, 16'h0000);
    rdc(4'hF, 16'h0000);
    $display("test offset done");
    for (int i = 0; i < 13; i++) begin
      if (tbl[i][7]) begin
        @(posedge sys_clk);
        par_cfg <= 1'b1;
        {mode_pin_one, mode_pin_two, mode_pin_three} <= tbl[i][6:4];
      end else begin
        wr(4'h2, {12'h000, tbl[i][3:0]});
      end
      idle(4);
      pe = pexp(tbl[i][3:0]);
      cmp({11'h000, {chan_a_oe, chan_b_oe, conv_a_on, conv_b_on, ref_on} & pe[9:5]}, {11'h000, pe[4:0]});
      rd(4'h3, d);
      cmp({12'h000, d[13:10]}, {12'h000, tbl[i][3:0]});
      if (tbl[i][7]) begin
        @(posedge sys_clk);
        {mode_pin_one, mode_pin_two, mode_pin_three} <= 3'h0;
        @(posedge sys_clk);
      end else begin
        wr(4'h2, 16'h0000);
      end
      wake(wk(tbl[i][3:0]));
    end
    @(posedge sys_clk);
    par_cfg <= 1'b0;
    samp_in <= '{a: 11'sd600, b: -11'sd600};
    wr(4'h2, 16'h000F);
    idle(30);
    @(negedge sys_clk);
    x1 = a_line;
    @(negedge sys_clk);
    x2 = a_line;
    cmp({15'h0000, (x1 === 11'h258 && x2 === 11'h5A8) || (x1 === 11'h5A8 && x2 === 11'h258)}, 16'h0001);
    $display("test power done");
    stop_test;
  end
endmodule // adc_digital_processing_control_tb
`default_nettype wire
